//--- logic/rsc_top.v
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "rsc_consts.vh"

module rsc_top (
    core_clk,
    rst,
    por_req,
    external_clear_pin_n,
    software_reset_req,
    watchdog_reset_source,
    brownout_req,
    deep_sleep_brownout_req,
    trap_conflict_req,
    bad_opcode_req,
    uninit_wreg_reset_source,
    sleep_wake_evt,
    idle_wake_evt,
    watchdog_timeout_evt,
    deep_sleep_wake_evt,
    config_mismatch_evt,
    addr,
    wr_data,
    wr_stb,
    rd_stb,
    rd_data,
    system_reset_out,
    irq,
    watchdog_sw_enable,
    brownout_sw_enable,
    retention_enable,
    prog_mem_sleep
);
    input wire core_clk;
    input wire rst;
    input wire por_req;
    input wire external_clear_pin_n;
    input wire software_reset_req;
    input wire watchdog_reset_source;
    input wire brownout_req;
    input wire deep_sleep_brownout_req;
    input wire trap_conflict_req;
    input wire bad_opcode_req;
    input wire uninit_wreg_reset_source;
    input wire sleep_wake_evt;
    input wire idle_wake_evt;
    input wire watchdog_timeout_evt;
    input wire deep_sleep_wake_evt;
    input wire config_mismatch_evt;
    input wire [`RSC_AW-1:0] addr;
    input wire [`RSC_DW-1:0] wr_data;
    input wire wr_stb;
    input wire rd_stb;
    output reg [`RSC_DW-1:0] rd_data;
    output wire system_reset_out;
    output reg irq;
    output reg watchdog_sw_enable;
    output reg brownout_sw_enable;
    output reg retention_enable;
    output reg prog_mem_sleep;

    // clear-on-one with hardware set taking priority over the clear
    function [`RSC_NSRC-1:0] rsc_w1c;
        input [`RSC_NSRC-1:0] cur;
        input [`RSC_NSRC-1:0] clr;
        input [`RSC_NSRC-1:0] set;
        begin
            rsc_w1c = (cur & ~clr) | set;
        end
    endfunction

    // zero-extend a source-wide vector onto the data bus
    function [`RSC_DW-1:0] rsc_ext;
        input [`RSC_NSRC-1:0] v;
        begin
            rsc_ext = {{(`RSC_DW-`RSC_NSRC){1'b0}}, v};
        end
    endfunction

    // one address compare shared by the write strobes
    function rsc_hit;
        input [`RSC_AW-1:0] a;
        input [`RSC_AW-1:0] target;
        begin
            rsc_hit = (a == target);
        end
    endfunction

    // saturates so a flapping requester cannot wrap the count to zero
    function [7:0] rsc_sat_inc;
        input [7:0] c;
        begin
            if (c == `RSC_CNT_MAX) begin
                rsc_sat_inc = c;
            end else begin
                rsc_sat_inc = c + `RSC_CNT_ONE;
            end
        end
    endfunction

    // requesters onto cause flags; paired requesters share one flag
    function [`RSC_DW-1:0] rsc_src_cause;
        input [`RSC_NSRC-1:0] s;
        reg [`RSC_DW-1:0] f;
        begin
            f = `RSC_D_ZERO;
            f[`RSC_B_PIN] = s[`RSC_S_PIN];
            f[`RSC_B_SWRST] = s[`RSC_S_SWRST];
            f[`RSC_B_WDTO] = s[`RSC_S_WDOG];
            f[`RSC_B_BROWN] = s[`RSC_S_BROWN] | s[`RSC_S_DSBROWN];
            f[`RSC_B_TRAP] = s[`RSC_S_TRAP];
            f[`RSC_B_BADOP] = s[`RSC_S_BADOP] | s[`RSC_S_UNWREG];
            rsc_src_cause = f;
        end
    endfunction

    // control bits back to defaults; status flags are kept
    function [`RSC_DW-1:0] rsc_ctl_force;
        input [`RSC_DW-1:0] v;
        begin
            rsc_ctl_force = (v & ~`RSC_CTL_MASK) | `RSC_CTL_RST;
        end
    endfunction

    // zero-extend the reset count onto the data bus
    function [`RSC_DW-1:0] rsc_ext_cnt;
        input [7:0] c;
        begin
            rsc_ext_cnt = {`RSC_CNT_PAD, c};
        end
    endfunction

    wire [`RSC_NSRC-1:0] src;
    wire [`RSC_NSRC-1:0] src_rise;
    wire sys_rst;
    wire wr_cause;
    wire wr_stat;
    wire wr_mask;
    wire wr_count;

    reg [`RSC_DW-1:0] cause_r;
    reg [`RSC_DW-1:0] cause_nxt;
    reg [`RSC_DW-1:0] cause_hw_set;
    reg [`RSC_NSRC-1:0] irq_stat_r;
    reg [`RSC_NSRC-1:0] irq_stat_nxt;
    reg [`RSC_NSRC-1:0] stat_clr;
    reg [`RSC_NSRC-1:0] irq_mask_r;
    reg [`RSC_NSRC-1:0] irq_mask_nxt;
    reg [7:0] rst_count_r;
    reg [7:0] rst_count_nxt;
    reg sys_rst_d_r;
    reg [`RSC_DW-1:0] rd_nxt;

    // pin is active low; every other requester is active high
    assign src[`RSC_S_PWRON] = por_req;
    assign src[`RSC_S_PIN] = ~external_clear_pin_n;
    assign src[`RSC_S_SWRST] = software_reset_req;
    assign src[`RSC_S_WDOG] = watchdog_reset_source;
    assign src[`RSC_S_BROWN] = brownout_req;
    assign src[`RSC_S_DSBROWN] = deep_sleep_brownout_req;
    assign src[`RSC_S_TRAP] = trap_conflict_req;
    assign src[`RSC_S_BADOP] = bad_opcode_req;
    assign src[`RSC_S_UNWREG] = uninit_wreg_reset_source;

    // software writes never reach src, so a flag write cannot reset
    rsc_reset_gen u_gen (
        .core_clk(core_clk),
        .rst(rst),
        .src(src),
        .sys_rst(sys_rst)
    );

    rsc_src_edge u_edge (
        .core_clk(core_clk),
        .rst(rst),
        .src(src),
        .rise(src_rise)
    );

    assign system_reset_out = sys_rst;

    assign wr_cause = wr_stb && rsc_hit(addr, `RSC_ADDR_CAUSE);
    assign wr_stat = wr_stb && rsc_hit(addr, `RSC_ADDR_IRQ_STAT);
    assign wr_mask = wr_stb && rsc_hit(addr, `RSC_ADDR_IRQ_MASK);
    assign wr_count = wr_stb && rsc_hit(addr, `RSC_ADDR_COUNT);

    // flags set while a source or status event is active
    always @* begin
        cause_hw_set = rsc_src_cause(src);
        cause_hw_set[`RSC_B_WDTO] = cause_hw_set[`RSC_B_WDTO] | watchdog_timeout_evt;
        cause_hw_set[`RSC_B_SLEEP] = sleep_wake_evt;
        cause_hw_set[`RSC_B_IDLE] = idle_wake_evt;
        cause_hw_set[`RSC_B_DSLP] = deep_sleep_wake_evt;
        cause_hw_set[`RSC_B_CFGM] = config_mismatch_evt;
    end

    // write takes the word less unimplemented bit 11, then reset forcing, then hardware sets, then a power-on request loads the power-on pattern over all
    always @* begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = wr_data & `RSC_CAUSE_IMPL;
        end
        if (sys_rst) begin
            cause_nxt = rsc_ctl_force(cause_nxt);
        end
        cause_nxt = cause_nxt | cause_hw_set;
        if (src[`RSC_S_PWRON]) begin
            cause_nxt = `RSC_CAUSE_POR_VAL;
        end
    end

    // rst stands for the supply coming up: power-on pattern
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cause_r <= `RSC_CAUSE_POR_VAL;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // control outputs follow their stored bits
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            watchdog_sw_enable <= 1'b0;
            brownout_sw_enable <= 1'b0;
            retention_enable <= 1'b0;
            prog_mem_sleep <= 1'b0;
        end else begin
            watchdog_sw_enable <= cause_nxt[`RSC_B_WDEN];
            brownout_sw_enable <= cause_nxt[`RSC_B_BOEN];
            retention_enable <= cause_nxt[`RSC_B_RETEN];
            prog_mem_sleep <= cause_nxt[`RSC_B_PMSLP];
        end
    end

    // interrupt status: one sticky bit per source on its rising edge
    always @* begin
        stat_clr = `RSC_SRC_ZERO;
        if (wr_stat) begin
            stat_clr = wr_data[`RSC_NSRC-1:0];
        end
        irq_stat_nxt = rsc_w1c(irq_stat_r, stat_clr, src_rise);
    end

    always @* begin
        irq_mask_nxt = irq_mask_r;
        if (wr_mask) begin
            irq_mask_nxt = wr_data[`RSC_NSRC-1:0];
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= `RSC_SRC_ZERO;
            irq_mask_r <= `RSC_SRC_ZERO;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    // counts completed system resets; saturates rather than wrapping
    always @* begin
        rst_count_nxt = rst_count_r;
        if (wr_count) begin
            rst_count_nxt = `RSC_CNT_ZERO;
        end else if (sys_rst_d_r && !sys_rst) begin
            rst_count_nxt = rsc_sat_inc(rst_count_r);
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rst_count_r <= `RSC_CNT_ZERO;
            sys_rst_d_r <= 1'b1;
        end else begin
            rst_count_r <= rst_count_nxt;
            sys_rst_d_r <= sys_rst;
        end
    end

    // read data valid only in the cycle after the strobe
    always @* begin
        rd_nxt = `RSC_D_ZERO;
        if (rd_stb) begin
            case (addr)
                `RSC_ADDR_CAUSE: begin
                    rd_nxt = cause_r;
                end
                `RSC_ADDR_IRQ_STAT: begin
                    rd_nxt = rsc_ext(irq_stat_r);
                end
                `RSC_ADDR_IRQ_MASK: begin
                    rd_nxt = rsc_ext(irq_mask_r);
                end
                `RSC_ADDR_LIVE: begin
                    rd_nxt = rsc_ext(src);
                end
                `RSC_ADDR_COUNT: begin
                    rd_nxt = rsc_ext_cnt(rst_count_r);
                end
                default: begin
                    rd_nxt = `RSC_D_ZERO;
                end
            endcase
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data <= `RSC_D_ZERO;
        end else begin
            rd_data <= rd_nxt;
        end
    end
endmodule

//--- logic/rsc_consts.vh
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

`define RSC_AW 16
`define RSC_DW 16
`define RSC_NSRC 9

// register map
`define RSC_ADDR_CAUSE 16'h0740
`define RSC_ADDR_IRQ_STAT 16'h07A0
`define RSC_ADDR_IRQ_MASK 16'h07A2
`define RSC_ADDR_LIVE 16'h07A4
`define RSC_ADDR_COUNT 16'h07A6

// reset cause register fields
`define RSC_B_TRAP 15
`define RSC_B_BADOP 14
`define RSC_B_BOEN 13
`define RSC_B_RETEN 12
`define RSC_B_DSLP 10
`define RSC_B_CFGM 9
`define RSC_B_PMSLP 8
`define RSC_B_PIN 7
`define RSC_B_SWRST 6
`define RSC_B_WDEN 5
`define RSC_B_WDTO 4
`define RSC_B_SLEEP 3
`define RSC_B_IDLE 2
`define RSC_B_BROWN 1
`define RSC_B_PWRON 0

`define RSC_CAUSE_IMPL 16'hF7FF
`define RSC_CAUSE_POR_VAL 16'h0003
`define RSC_CTL_MASK 16'h3120
`define RSC_CTL_RST 16'h0000

// source vector positions, also interrupt status layout
`define RSC_S_PWRON 0
`define RSC_S_PIN 1
`define RSC_S_SWRST 2
`define RSC_S_WDOG 3
`define RSC_S_BROWN 4
`define RSC_S_DSBROWN 5
`define RSC_S_TRAP 6
`define RSC_S_BADOP 7
`define RSC_S_UNWREG 8
`define RSC_SRC_ZERO 9'h000
`define RSC_CNT_ZERO 8'h00
`define RSC_CNT_ONE 8'h01
`define RSC_CNT_MAX 8'hFF
`define RSC_CNT_PAD 8'h00
`define RSC_D_ZERO 16'h0000

`endif

//--- logic/rsc_src_edge.v
`timescale 1ns/1ns
`include "rsc_consts.vh"

module rsc_src_edge (
    core_clk,
    rst,
    src,
    rise
);
    input wire core_clk;
    input wire rst;
    input wire [`RSC_NSRC-1:0] src;
    output wire [`RSC_NSRC-1:0] rise;

    reg [`RSC_NSRC-1:0] prev_r;

    // prev starts clear so a source held through rst gives one event
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_r <= `RSC_SRC_ZERO;
        end else begin
            prev_r <= src;
        end
    end

    assign rise = src & ~prev_r;
endmodule

//--- logic/rsc_reset_gen.v
`timescale 1ns/1ns
`include "rsc_consts.vh"

module rsc_reset_gen (
    core_clk,
    rst,
    src,
    sys_rst
);
    input wire core_clk;
    input wire rst;
    input wire [`RSC_NSRC-1:0] src;
    output wire sys_rst;

    reg sys_rst_r;

    // held asserted through rst; drops on the first edge with no source
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sys_rst_r <= 1'b1;
        end else begin
            sys_rst_r <= |src;
        end
    end

    assign sys_rst = sys_rst_r;
endmodule

//--- verification/rsc_top_properties.sv
`timescale 1ns/1ns
`include "rsc_consts.vh"

module rsc_chk (
    input wire core_clk,
    rst,
    por_req,
    external_clear_pin_n,
    software_reset_req,
    watchdog_reset_source,
    brownout_req,
    deep_sleep_brownout_req,
    trap_conflict_req,
    bad_opcode_req,
    uninit_wreg_reset_source,
    wr_stb,
    rd_stb,
    system_reset_out,
    irq,
    watchdog_sw_enable,
    brownout_sw_enable,
    retention_enable,
    prog_mem_sleep,
    input wire [`RSC_AW-1:0] addr,
    input wire [`RSC_DW-1:0] rd_data
);
    wire any_src = por_req | ~external_clear_pin_n | software_reset_req | watchdog_reset_source
        | brownout_req | deep_sleep_brownout_req | trap_conflict_req | bad_opcode_req
        | uninit_wreg_reset_source;
    wire [3:0] ctl = {watchdog_sw_enable, brownout_sw_enable, retention_enable, prog_mem_sleep};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_any_src_rst: assert property (any_src |=> system_reset_out)
        else $error("reset not raised by source");
    a_held_while_src: assert property (any_src ##1 any_src |-> system_reset_out)
        else $error("reset dropped while source active");
    a_sync_release: assert property (!any_src |=> !system_reset_out)
        else $error("reset late after sources released");
    a_write_no_rst: assert property (wr_stb && !any_src |=> !system_reset_out)
        else $error("software write caused reset");
    // copies are taken from the forced next value, so one cycle suffices
    a_ctl_forced: assert property (system_reset_out |=> ctl == 4'h0)
        else $error("control bits not forced during reset");
    a_ctl_hold: assert property ((!wr_stb && !system_reset_out) [*3] |-> $stable(ctl))
        else $error("control bits changed without write");
    a_rd_idle_zero: assert property (!rd_stb |=> rd_data == 16'h0000)
        else $error("read data not zero when idle");
    a_rd_unmapped: assert property (rd_stb && addr == 16'h0742 |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    c_por: cover property (por_req ##1 system_reset_out);
    c_irq: cover property ($rose(irq));
    c_rd_cause: cover property (rd_stb && addr == `RSC_ADDR_CAUSE);
endmodule

bind rsc_top rsc_chk chk_i (.*);

//--- verification/rsc_req_model.sv
`timescale 1ns/1ns

module rsc_req_model (
    input wire core_clk,
    rst,
    go,
    input wire [3:0] idx,
    len,
    output wire [8:0] src
);
    reg [3:0] cnt_r;
    reg [3:0] sel_r;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
            sel_r <= 4'h0;
        end else if (go) begin
            cnt_r <= len;
            sel_r <= idx;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    // one requester at a time, held len cycles; pin line is active low
    wire [8:0] act = (cnt_r != 4'h0) ? (9'h001 << sel_r) : 9'h000;
    assign src = act ^ 9'h002;
endmodule

//--- verification/rsc_top_tb_top.sv
`timescale 1ns/1ns
`include "rsc_consts.vh"

module rsc_top_tb_top;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg go = 1'b0;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg [3:0] idx = 4'h0;
    reg [3:0] len = 4'h0;
    reg [4:0] ev = 5'h00;
    reg [15:0] addr = 16'h0000;
    reg [15:0] wr_data = 16'h0000;
    reg [31:0] seed = 32'h00013C07;
    reg [15:0] v;
    reg [15:0] m;
    wire [15:0] rd_data;
    wire [8:0] s;
    wire sys, irq, wden, boen, reten, pms;
    integer err_total = 0;
    integer num_checks = 0;
    integer i;
    always #20 core_clk = ~core_clk;
    rsc_req_model PM (.core_clk(core_clk), .rst(rst), .go(go), .idx(idx), .len(len), .src(s));
    rsc_top DUT (.core_clk(core_clk), .rst(rst), .por_req(s[0]), .external_clear_pin_n(s[1]),
        .software_reset_req(s[2]), .watchdog_reset_source(s[3]), .brownout_req(s[4]),
        .deep_sleep_brownout_req(s[5]), .trap_conflict_req(s[6]), .bad_opcode_req(s[7]),
        .uninit_wreg_reset_source(s[8]), .sleep_wake_evt(ev[0]), .idle_wake_evt(ev[1]),
        .watchdog_timeout_evt(ev[2]), .deep_sleep_wake_evt(ev[3]), .config_mismatch_evt(ev[4]),
        .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .system_reset_out(sys), .irq(irq), .watchdog_sw_enable(wden), .brownout_sw_enable(boen),
        .retention_enable(reten), .prog_mem_sleep(pms));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    function [15:0] exp_cause(input [3:0] k);
        case (k)
            4'h0: exp_cause = `RSC_CAUSE_POR_VAL;
            4'h1: exp_cause = 16'h0080;
            4'h2: exp_cause = 16'h0040;
            4'h3, 4'hB: exp_cause = 16'h0010;
            4'h4, 4'h5: exp_cause = 16'h0002;
            4'h6: exp_cause = 16'h8000;
            4'h7, 4'h8: exp_cause = 16'h4000;
            4'h9: exp_cause = 16'h0008;
            4'hA: exp_cause = 16'h0004;
            4'hC: exp_cause = 16'h0400;
            default: exp_cause = 16'h0200;
        endcase
    endfunction
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [15:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            addr <= a;
            wr_data <= d;
            wr_stb <= 1'b1;
            @(posedge core_clk);
            wr_stb <= 1'b0;
        end
    endtask
    task rc(input string nm, input [15:0] a, input [15:0] e);
        begin
            @(posedge core_clk);
            addr <= a;
            rd_stb <= 1'b1;
            @(posedge core_clk);
            rd_stb <= 1'b0;
            #1 chk(nm, rd_data, e);
        end
    endtask
    task final_report;
        begin
            if (err_total == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #400000;
        err_total = err_total + 1;
        final_report;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rc("cause after power-up", `RSC_ADDR_CAUSE, `RSC_CAUSE_POR_VAL);
        rc("unmapped", 16'h0742, 16'h0000);
        for (i = 0; i < 6; i = i + 1) begin
            seed = xs(seed);
            v = (i == 0) ? 16'hFFFF : seed[15:0];
            wr(`RSC_ADDR_CAUSE, v);
            rc("cause rw", `RSC_ADDR_CAUSE, v & `RSC_CAUSE_IMPL);
            chk("ctl outs", {12'h000, wden, boen, reten, pms}, {12'h000, v[5], v[13], v[12], v[8]});
            chk("no reset", {15'h0000, sys}, 16'h0000);
        end
        for (i = 0; i < 14; i = i + 1) begin
            seed = xs(seed);
            m = {7'h00, seed[24:16]};
            wr(`RSC_ADDR_IRQ_STAT, 16'h01FF);
            wr(`RSC_ADDR_IRQ_MASK, m);
            // stale flags would hide which source came last
            wr(`RSC_ADDR_CAUSE, (i == 0) ? 16'hFFFF : 16'h0000);
            @(posedge core_clk);
            if (i < 9) begin
                idx <= i[3:0];
                len <= (i == 8) ? 4'h1 : 4'h2 + {1'b0, seed[2:0]};
                go <= 1'b1;
            end else begin
                ev[i-9] <= 1'b1;
            end
            @(posedge core_clk);
            go <= 1'b0;
            ev <= 5'h00;
            @(posedge core_clk);
            #1 chk("reset raised", {15'h0000, sys}, (i < 9) ? 16'h0001 : 16'h0000);
            repeat (12) @(posedge core_clk);
            #1 chk("reset released", {15'h0000, sys}, 16'h0000);
            rc("cause flag", `RSC_ADDR_CAUSE, exp_cause(i[3:0]));
            if (i > 0 && i < 9) begin
                chk("irq level", {15'h0000, irq}, {15'h0000, m[i]});
                rc("irq status", `RSC_ADDR_IRQ_STAT, 16'h0001 << i);
                wr(`RSC_ADDR_IRQ_STAT, 16'h01FF);
                repeat (2) @(posedge core_clk);
                #1 chk("irq cleared", {15'h0000, irq}, 16'h0000);
            end
        end
        // power-up release plus nine requester pulses
        rc("reset count", `RSC_ADDR_COUNT, 16'h000A);
        wr(`RSC_ADDR_COUNT, 16'h0000);
        rc("count cleared", `RSC_ADDR_COUNT, 16'h0000);
        rc("live idle", `RSC_ADDR_LIVE, 16'h0000);
        // mid-run power-up must wipe a dirty cause word
        wr(`RSC_ADDR_CAUSE, 16'hFFFF);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1 chk("reset in rst", {15'h0000, sys}, 16'h0001);
        chk("ctl in rst", {12'h000, wden, boen, reten, pms}, 16'h0000);
        rc("cause after rst", `RSC_ADDR_CAUSE, `RSC_CAUSE_POR_VAL);
        final_report;
    end
endmodule
